// *** dacr_chk.sv ***
`timescale 1ns/1ps
module dacr_chk
  import dacr_pkg::*;
#(
  parameter int CONV_DELAY_CYCLES = CONV_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [23:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic io_hit,
  input wire logic [7:0] port3_func_ain,
  input wire logic port3_pin6_aout,
  input wire logic conv_output_enable,
  input wire logic conv_busy,
  input wire logic analog_out_a_valid,
  input wire logic [7:0] analog_out_a
);
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  // small slack over the delay for the busy and output register stages
  localparam int LIM = CONV_DELAY_CYCLES + 2;
  wire logic wr_ctl = io_wr && io_addr == ADDR_OUTPUT_CONTROL;
  wire logic wr_rt = io_wr && io_addr == ADDR_ANALOG_OUTPUT_ROUTING;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_en_wr;
    wr_ctl |=> conv_output_enable == $past(io_wdata[0]);
  endproperty
  a_en_wr: assert property (p_en_wr) else $error("enable write lost");
  property p_rst;
    $fell(sys_rst) |-> !conv_output_enable && !port3_pin6_aout && !conv_busy;
  endproperty
  a_rst: assert property (p_rst) else $error("state after reset");
  property p_hit;
    io_rd && io_addr == ADDR_CONVERSION_VALUE |=> io_hit;
  endproperty
  a_hit: assert property (p_hit) else $error("mapped read missed");
  property p_route;
    wr_rt |=> port3_pin6_aout == $past(io_wdata[6]);
  endproperty
  a_route: assert property (p_route) else $error("route bit wrong");
  property p_pri;
    port3_pin6_aout |-> !port3_func_ain[6];
  endproperty
  a_pri: assert property (p_pri) else $error("input beats output");
  property p_gnd;
    !conv_output_enable ##1 !conv_output_enable |->
      analog_out_a == 8'h00 && !analog_out_a_valid;
  endproperty
  a_gnd: assert property (p_gnd) else $error("disabled out not ground");
  property p_busy;
    $rose(conv_busy) |-> ##[1:LIM] !conv_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("conversion too long");
  property p_outv;
    $fell(conv_busy) && conv_output_enable && port3_pin6_aout |->
      ##[0:2] analog_out_a_valid;
  endproperty
  a_outv: assert property (p_outv) else $error("result not shown");
  property p_unused;
    io_rd && io_addr == ADDR_OUTPUT_CONTROL |=> io_rdata[7:1] == 7'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits set");
  c_conv: cover property (analog_out_a_valid);
  c_route: cover property (wr_rt ##1 port3_pin6_aout);
  c_off: cover property ($fell(conv_output_enable));
endmodule
bind dacr_top dacr_chk #(.CONV_DELAY_CYCLES(CONV_DELAY_CYCLES)) u_dacr_chk (.*);

// *** dacr_conv_timer.sv ***
`timescale 1ns/1ps
module dacr_conv_timer
  import dacr_pkg::*;
#(
  parameter int CYCLES = CONV_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic abort,
  input wire logic [7:0] value,
  output logic busy,
  output logic settled,
  output logic [7:0] result
);

  localparam int CW = $clog2(CYCLES + 1);
  // the output register adds one more stage, so the count ends a cycle
  // early and the code reaches the pin no later than CYCLES after a write
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 2);

  logic [CW-1:0] cnt_q;
  logic busy_q;
  logic settled_q;
  logic [7:0] hold_q;
  logic [7:0] result_q;
  wire done = busy_q && (cnt_q == LAST);

  // ----------------------------------------------------------------------
  // conversion delay: latch on start, present one cycle before the full delay
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst || abort) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      settled_q <= 1'b0;
      hold_q <= RESET_VALUE;
      result_q <= RESET_VALUE;
    end else if (start) begin
      cnt_q <= '0;
      busy_q <= 1'b1;
      hold_q <= value;
    end else if (done) begin
      busy_q <= 1'b0;
      settled_q <= 1'b1;
      result_q <= hold_q;
    end else if (busy_q) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign busy = busy_q;
  assign settled = settled_q;
  assign result = result_q;

endmodule

// *** dacr_pkg.sv ***
package dacr_pkg;

  // ----------------------------------------------------------------------
  // register addresses (i/o memory, 24-bit)
  // ----------------------------------------------------------------------
  localparam logic [23:0] ADDR_OUTPUT_CONTROL = 24'h00ff90;
  localparam logic [23:0] ADDR_CONVERSION_VALUE = 24'h00ff91;
  localparam logic [23:0] ADDR_ANALOG_INPUT_SELECT = 24'h00ffe8;
  localparam logic [23:0] ADDR_ANALOG_OUTPUT_ROUTING = 24'h00ffe9;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int BIT_CONV_OUTPUT_ENABLE = 0;
  localparam int BIT_OUT_ROUTE_CH0 = 6;
  localparam int BIT_OUT_ROUTE_CH1 = 7;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] ROUTE_MASK = 8'hc0;
  localparam logic [7:0] ENABLE_MASK = 8'h01;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TIME_US = 30;
  // longest time rounds down
  localparam int CONV_CYCLES = (CONV_TIME_US * 1000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DACR_PIN_GPIO = 2'b00,
    DACR_PIN_AIN = 2'b01,
    DACR_PIN_AOUT = 2'b10
  } dacr_pin_mode_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dacr_bus_req_t;

  typedef struct packed {
    logic drive_value;
    logic [7:0] level;
  } dacr_aout_t;

endpackage

// *** dacr_top.sv ***
`timescale 1ns/1ps
// Functional notes
// [R01] enable bit d0 at ff90, readable
// [R02] enable resets to zero
// [R03] eight-bit conversion value, resets zero
// [R04] route bit 6 puts pin6 on channel 0
// [R05] route bit 7 puts pin7 on channel 1
// [R06] cleared route bit restores port function
// [R07] one value drives either routed pin
// [R08] software never sets both route bits
// [R09] route bits reset to zero
// [R10] input select bits pick analog input
// [R11] output route beats input select
// [R12] software keeps input select zero there
// [R13] input select bits reset to zero
// [R14] disabled output holds analog ground
// [R15] value write restarts conversion, 30us max
// [R16] unused bits read zero, ignore writes
module dacr_top
  import dacr_pkg::*;
#(
  parameter int CONV_DELAY_CYCLES = CONV_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [23:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  output logic io_hit,
  output logic [7:0] port3_func_ain,
  output logic port3_pin6_aout,
  output logic port3_pin7_aout,
  output logic conv_output_enable,
  output logic conv_busy,
  output logic analog_out_a_valid,
  output logic [7:0] analog_out_a,
  output logic analog_out_b_valid,
  output logic [7:0] analog_out_b
);

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  dacr_bus_req_t req;
  assign req = '{addr: io_addr, wdata: io_wdata, wr: io_wr, rd: io_rd};

  wire sel_ctl = (req.addr == ADDR_OUTPUT_CONTROL);
  wire sel_val = (req.addr == ADDR_CONVERSION_VALUE);
  wire sel_ain = (req.addr == ADDR_ANALOG_INPUT_SELECT);
  wire sel_rte = (req.addr == ADDR_ANALOG_OUTPUT_ROUTING);
  wire wr_ctl = req.wr && sel_ctl;
  wire wr_val = req.wr && sel_val;
  wire wr_ain = req.wr && sel_ain;
  wire wr_rte = req.wr && sel_rte;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic enable_q;
  logic [7:0] conversion_value_q;
  logic [7:0] ain_select_q;
  logic [7:0] out_route_bits_q;
  logic [7:0] rdata_q;

  wire enable_d = wr_ctl ? req.wdata[BIT_CONV_OUTPUT_ENABLE] : enable_q; // R01
  wire [7:0] route_d = wr_rte ? (req.wdata & ROUTE_MASK) // R16
                              : out_route_bits_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      enable_q <= 1'b0; // R02
      conversion_value_q <= RESET_VALUE; // R03
      ain_select_q <= RESET_VALUE; // R13
      out_route_bits_q <= RESET_VALUE; // R09
    end else begin
      enable_q <= enable_d;
      out_route_bits_q <= route_d; // R06
      if (wr_val) begin
        conversion_value_q <= req.wdata; // R03
      end
      if (wr_ain) begin
        ain_select_q <= req.wdata; // R10
      end
    end
  end

  // ----------------------------------------------------------------------
  // read path: registered data, one cycle after the read strobe
  // ----------------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = RESET_VALUE;
    if (sel_ctl) begin
      rd_mux = {7'h00, enable_q} & ENABLE_MASK; // R16
    end else if (sel_val) begin
      rd_mux = conversion_value_q;
    end else if (sel_ain) begin
      rd_mux = ain_select_q;
    end else if (sel_rte) begin
      rd_mux = out_route_bits_q & ROUTE_MASK; // R16
    end
  end

  logic hit_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_q <= RESET_VALUE;
      hit_q <= 1'b0;
    end else begin
      rdata_q <= req.rd ? rd_mux : rdata_q;
      hit_q <= req.rd && (sel_ctl || sel_val || sel_ain || sel_rte);
    end
  end

  assign io_rdata = rdata_q;
  assign io_hit = hit_q;

  // ----------------------------------------------------------------------
  // pin function
  // ----------------------------------------------------------------------
  wire route0 = out_route_bits_q[BIT_OUT_ROUTE_CH0]; // R04
  wire route1 = out_route_bits_q[BIT_OUT_ROUTE_CH1]; // R05
  // the route bits win: analog input is masked off on a routed pin
  assign port3_func_ain = ain_select_q & ~(out_route_bits_q & ROUTE_MASK); // R11
  assign port3_pin6_aout = route0; // R04
  assign port3_pin7_aout = route1; // R05
  assign conv_output_enable = enable_q;

  // ----------------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------------
  // a rising enable, or a value write while enabled, restarts the delay
  wire start_conv = (enable_d && !enable_q) || (enable_q && wr_val); // R15
  wire [7:0] conv_src = wr_val ? req.wdata : conversion_value_q;
  wire settled;
  wire [7:0] result;

  dacr_conv_timer #(
    .CYCLES(CONV_DELAY_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(start_conv),
    .abort(!enable_d),
    .value(conv_src),
    .busy(conv_busy),
    .settled(settled),
    .result(result)
  );

  // ----------------------------------------------------------------------
  // analog outputs: ground level (0) until a result is presented
  // ----------------------------------------------------------------------
  // both channels share one converter; if software routes both pins at
  // once they simply carry the same level, nothing is protected here
  wire live = enable_q && settled; // R14
  dacr_aout_t ch_a;
  dacr_aout_t ch_b;
  assign ch_a = '{drive_value: live && route0,
                  level: (live && route0) ? result : RESET_VALUE}; // R07
  assign ch_b = '{drive_value: live && route1,
                  level: (live && route1) ? result : RESET_VALUE}; // R07

  logic [7:0] out_a_q;
  logic [7:0] out_b_q;
  logic va_q;
  logic vb_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out_a_q <= RESET_VALUE;
      out_b_q <= RESET_VALUE;
      va_q <= 1'b0;
      vb_q <= 1'b0;
    end else begin
      out_a_q <= ch_a.level;
      out_b_q <= ch_b.level;
      va_q <= ch_a.drive_value;
      vb_q <= ch_b.drive_value;
    end
  end

  assign analog_out_a = out_a_q;
  assign analog_out_b = out_b_q;
  assign analog_out_a_valid = va_q;
  assign analog_out_b_valid = vb_q;

endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import dacr_pkg::*;
  // short delay keeps the run brief; the conversion wait derives from it
  localparam int CD = 4;
  logic clk_sys, sys_rst, io_wr, io_rd, io_hit, conv_busy;
  logic [23:0] io_addr;
  logic [7:0] io_wdata, io_rdata, port3_func_ain, analog_out_a, analog_out_b;
  logic port3_pin6_aout, port3_pin7_aout, conv_output_enable;
  logic analog_out_a_valid, analog_out_b_valid;
  int err_count = 0;
  int samples_checked = 0;
  dacr_top #(.CONV_DELAY_CYCLES(CD)) u_dacr_top (.*);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------------
  // bus cycles and checks
  // ----------------------------------------------------------------------
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(logic [23:0] a, logic [7:0] d);
    @(posedge clk_sys);
    #10 io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clk_sys);
    #10 io_wr = 1'b0;
  endtask
  task automatic rd(logic [23:0] a, logic [7:0] e, logic h);
    @(posedge clk_sys);
    #10 io_addr = a;
    io_rd = 1'b1;
    @(posedge clk_sys);
    #10 io_rd = 1'b0;
    chk(io_rdata, e);
    chk({7'h00, io_hit}, {7'h00, h});
  endtask
  function automatic logic [7:0] pins();
    return {6'h00, port3_pin7_aout, port3_pin6_aout};
  endfunction
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    rd(ADDR_OUTPUT_CONTROL, 8'h00, 1'b1);
    rd(ADDR_CONVERSION_VALUE, 8'h00, 1'b1);
    rd(ADDR_ANALOG_INPUT_SELECT, 8'h00, 1'b1);
    rd(ADDR_ANALOG_OUTPUT_ROUTING, 8'h00, 1'b1);
  endtask
  task automatic t_regs;
    wr(ADDR_OUTPUT_CONTROL, 8'hfe);
    rd(ADDR_OUTPUT_CONTROL, 8'h00, 1'b1);
    wr(ADDR_CONVERSION_VALUE, 8'ha5);
    chk({7'h00, conv_busy}, 8'h00);
    rd(ADDR_CONVERSION_VALUE, 8'ha5, 1'b1);
    wr(ADDR_ANALOG_INPUT_SELECT, 8'hff);
    rd(ADDR_ANALOG_INPUT_SELECT, 8'hff, 1'b1);
    wr(ADDR_ANALOG_OUTPUT_ROUTING, 8'h7f);
    rd(ADDR_ANALOG_OUTPUT_ROUTING, 8'h40, 1'b1);
    chk(port3_func_ain, 8'hbf);
    chk(pins(), 8'h01);
    wr(ADDR_ANALOG_OUTPUT_ROUTING, 8'h80);
    chk(port3_func_ain, 8'h7f);
    chk(pins(), 8'h02);
    wr(ADDR_ANALOG_OUTPUT_ROUTING, 8'h00);
    chk(port3_func_ain, 8'hff);
    chk(pins(), 8'h00);
    wr(24'h00ff92, 8'h55);
    rd(24'h00ff92, 8'h00, 1'b0);
    wr(ADDR_ANALOG_INPUT_SELECT, 8'h00);
  endtask
  task automatic t_conv(logic [7:0] rt, logic [7:0] v);
    wr(ADDR_ANALOG_OUTPUT_ROUTING, rt);
    wr(ADDR_CONVERSION_VALUE, v);
    chk({7'h00, conv_busy}, 8'h01);
    repeat (CD + 2) @(posedge clk_sys);
    #10 chk({7'h00, conv_busy}, 8'h00);
    chk(rt[6] ? analog_out_a : analog_out_b, v);
    chk(rt[6] ? analog_out_b : analog_out_a, 8'h00);
    chk({6'h00, analog_out_b_valid, analog_out_a_valid}, rt >> 6);
  endtask
  task automatic t_off;
    wr(ADDR_OUTPUT_CONTROL, 8'h00);
    repeat (2) @(posedge clk_sys);
    #10 chk(analog_out_b, 8'h00);
    chk({7'h00, analog_out_b_valid}, 8'h00);
    rd(ADDR_OUTPUT_CONTROL, 8'h00, 1'b1);
  endtask
  initial begin
    sys_rst = 1'b1;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 24'h000000;
    io_wdata = 8'h00;
    repeat (3) @(posedge clk_sys);
    #10 sys_rst = 1'b0;
    t_reset;
    t_regs;
    wr(ADDR_OUTPUT_CONTROL, 8'h01);
    rd(ADDR_OUTPUT_CONTROL, 8'h01, 1'b1);
    t_conv(8'h40, 8'h3c);
    t_conv(8'h80, 8'h5a);
    t_off;
    end_sim;
  end
  initial begin
    #100000;
    err_count++;
    end_sim;
  end
endmodule
